// ---- link_ctl_props.sv ----
// Purpose: concurrent checks on the port link register block
// Assumes: one clock, async active-low reset
// Notes:   bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module link_ctl_props
  import link_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  // config access
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [3:0]  cfg_be_in,
  input wire logic        cfg_wr_in,
  input wire logic        cfg_rd_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        cfg_rvalid_out,
  // link state and controls
  input wire ltssm_t      ltssm_state_in,
  input wire logic        retrain_req_out,
  input wire logic        link_disable_out,
  input wire logic        common_clk_out,
  input wire logic [2:0]  l0s_exit_lat_out,
  // transactions
  input wire logic        req_valid_in,
  input wire txn_req_t    req_in,
  input wire logic        cpl_valid_out,
  input wire cpl_t        cpl_out,
  input wire logic        drop_out,
  input wire logic        fwd_valid_out,
  input wire txn_req_t    fwd_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // decode helpers
  wire logic ctl_hit = cfg_addr_in[7:2] == 6'h1d;
  wire logic ctl_wr  = cfg_wr_in && ctl_hit && cfg_be_in[0];
  wire logic ctl_rd  = cfg_rd_in && ctl_hit;
  wire logic rq_go   = req_valid_in && link_disable_out;
  // status walks
  sequence in_train;
    ltssm_state_in inside {LT_CONFIG, LT_RECOVERY};
  endsequence
  sequence fail_walk;
    in_train ##1 ltssm_state_in == LT_DETECT;
  endsequence
  ////////////////////////////////////////
  rd_answer_a: assert property (cfg_rvalid_out == $past(cfg_rd_in)) else $error("read answer wrong");
  fixed_bits_a: assert property (ctl_rd |=> cfg_rdata_out[31:28] == 4'h1 && cfg_rdata_out[19:16] == 4'h1
    && cfg_rdata_out[15:8] == 8'h00 && cfg_rdata_out[5] == 1'b0 && cfg_rdata_out[3:2] == 2'h0)
    else $error("fixed bits wrong");
  retrain_go_a: assert property (ctl_wr && cfg_wdata_in[5] |=> retrain_req_out) else $error("no retrain");
  retrain_idle_a: assert property (!(ctl_wr && cfg_wdata_in[5]) |=> !retrain_req_out) else $error("stray retrain");
  ctl_write_a: assert property (ctl_wr |=> link_disable_out == $past(cfg_wdata_in[4])
    && common_clk_out == $past(cfg_wdata_in[6])) else $error("control write lost");
  l0s_lat_a: assert property (l0s_exit_lat_out == (common_clk_out ? 3'h2 : 3'h6)) else $error("l0s latency");
  train_set_a: assert property (in_train ##1 ctl_rd |=> cfg_rdata_out[27]) else $error("training not set");
  train_done_a: assert property (ltssm_state_in == LT_L0 ##1 ctl_rd |=> !cfg_rdata_out[27]) else $error("training");
  train_err_a: assert property (fail_walk ##1 ctl_rd |=> cfg_rdata_out[26]) else $error("no training error");
  abort_read_a: assert property (rq_go && req_in.kind inside {TK_READ, TK_OTHER} |=> cpl_valid_out
    && cpl_out.status == CS_MASTER_ABORT && cpl_out.data == 32'hffffffff && cpl_out.tag == $past(req_in.tag))
    else $error("read abort wrong");
  posted_drop_a: assert property (rq_go && req_in.kind == TK_POSTED_WR |=> drop_out && !cpl_valid_out)
    else $error("posted not dropped");
  io_done_a: assert property (rq_go && req_in.kind == TK_IO_WR |=> cpl_valid_out && cpl_out.status == CS_DONE)
    else $error("io write not done");
  fwd_live_a: assert property (req_valid_in && !link_disable_out |=> fwd_valid_out && fwd_out == $past(req_in))
    else $error("not forwarded");
endmodule : link_ctl_props
bind port_link_ctl_sts link_ctl_props link_ctl_props_inst (.sys_clk_in, .resetn_in, .cfg_addr_in, .cfg_be_in,
  .cfg_wr_in, .cfg_rd_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .ltssm_state_in, .retrain_req_out,
  .link_disable_out, .common_clk_out, .l0s_exit_lat_out, .req_valid_in, .req_in, .cpl_valid_out, .cpl_out,
  .drop_out, .fwd_valid_out, .fwd_out);
`default_nettype wire

// ---- link_phy_model.sv ----
// Purpose: link partner model driving training state and width
// Assumes: same clock as the port
// Notes:   fail_in sends training back to detect
`timescale 1ns/1ps
`default_nettype none
module link_phy_model
  import link_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  // port controls
  input  wire logic       retrain_in,
  input  wire logic       disable_in,
  input  wire logic       fail_in,
  input  wire logic [5:0] width_cfg_in,
  // link state seen by the port
  output var  ltssm_t     state_out,
  output var  logic [5:0] width_out
);
  logic [1:0] cnt_r;  // dwell in training states
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_out <= LT_DETECT;
      cnt_r     <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (disable_in) begin
        state_out <= LT_DISABLED;
      end else if (state_out inside {LT_DETECT, LT_DISABLED}) begin
        state_out <= LT_CONFIG;
        cnt_r     <= 2'h0;
      end else if (state_out == LT_L0 && retrain_in) begin
        state_out <= LT_RECOVERY;
        cnt_r     <= 2'h0;
      end else if (state_out inside {LT_CONFIG, LT_RECOVERY} && cnt_r == 2'h3) begin
        state_out <= fail_in ? LT_DETECT : LT_L0;
      end
    end
  end
  // width lines float outside L0: show the inverse
  assign width_out = (state_out == LT_L0) ? width_cfg_in : ~width_cfg_in;
endmodule : link_phy_model
`default_nettype wire

// ---- link_pkg.sv ----
// Purpose: shared types of the port link register block
// Assumes: nothing beyond the register header
// Notes:   all state structs live here
package link_pkg;

  // training state machine states reported by the physical layer
  typedef enum logic [2:0] {
    LT_DETECT   = 3'b000,
    LT_POLLING  = 3'b001,
    LT_CONFIG   = 3'b010,
    LT_L0       = 3'b011,
    LT_RECOVERY = 3'b100,
    LT_L1       = 3'b101,
    LT_DISABLED = 3'b110
  } ltssm_t;

  // transaction kinds routed to the port
  typedef enum logic [1:0] {
    TK_POSTED_WR = 2'b00,
    TK_IO_WR     = 2'b01,
    TK_READ      = 2'b10,
    TK_OTHER     = 2'b11
  } txn_kind_t;

  // completion status made for a downed link
  typedef enum logic [1:0] {
    CS_DONE         = 2'b00,
    CS_MASTER_ABORT = 2'b01
  } cpl_status_t;

  // request routed to the port
  typedef struct packed {
    txn_kind_t   kind;
    logic [7:0]  tag;
  } txn_req_t;

  // completion made locally
  typedef struct packed {
    cpl_status_t status;
    logic [7:0]  tag;
    logic [31:0] data;
  } cpl_t;

  // software controls held in link_control
  typedef struct packed {
    logic       ext_sync;
    logic       common_clk;
    logic       link_disable;
    logic [1:0] aspm;
  } link_ctl_t;

  // state of the abort responder
  typedef struct packed {
    logic     cpl_valid;
    cpl_t     cpl;
    logic     drop;
    logic     fwd_valid;
    txn_req_t fwd;
  } resp_state_t;

  // state of the register block
  typedef struct packed {
    link_ctl_t   ctl;
    logic        retrain;
    logic        training;
    logic        train_err;
    logic [5:0]  width;
    ltssm_t      prev_lt;
    logic [31:0] rdata;
    logic        rvalid;
  } regs_state_t;

endpackage : link_pkg

// ---- link_regs.svh ----
// Purpose: register offsets, field positions and reset values of the port link registers
// Assumes: byte offsets in port_config_function configuration space
// Notes:   definitions only
`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH

// register byte offsets
`define LINK_CAP_OFF        8'h70
`define LINK_CTL_OFF        8'h74
`define LINK_STS_OFF        8'h76

// link_control field positions
`define CTL_EXT_SYNC_BIT    7
`define CTL_COMMON_CLK_BIT  6
`define CTL_RETRAIN_BIT     5
`define CTL_DISABLE_BIT     4
`define CTL_RCB_BIT         3
`define CTL_ASPM_LSB        0

// reset values
`define LINK_CTL_RESET      16'h0000
`define LINK_STS_RESET      16'h1001

// link_status constant fields
`define STS_SLOT_CLK        1'h1
`define STS_SPEED_2G5       4'h1
`define STS_WIDTH_NONE      6'h00
`define STS_WIDTH_X1        6'h01
`define STS_WIDTH_X4        6'h04
`define STS_WIDTH_X8        6'h08

// link capabilities fields
`define CAP_PORT_NUM        8'h02
`define CAP_L1_EXIT         3'h7
`define CAP_L0S_EXIT_ASYNC  3'h6
`define CAP_L0S_EXIT_COMMON 3'h2
`define CAP_ASPM_SUPPORT    2'h1
`define CAP_MAX_WIDTH       6'h08
`define CAP_MAX_SPEED       4'h1

// read data of a disabled port
`define ABORT_DATA          32'hffffffff

`endif

// ---- port_abort_responder.sv ----
// Purpose: routes decoded transactions to the link or answers them locally when the link is down
// Assumes: requests come from logic on the same clock
// Notes:   one request per cycle, answered one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "link_regs.svh"

module port_abort_responder
  import link_pkg::*;
(
  // clock and reset
  input  wire logic     sys_clk_in,
  input  wire logic     resetn_in,
  // control
  input  wire logic     link_disable_in,
  // routed request
  input  wire logic     req_valid_in,
  input  wire txn_req_t req_in,
  // local answer
  output var  logic     cpl_valid_out,
  output var  cpl_t     cpl_out,
  output var  logic     drop_out,
  // request toward a live link
  output var  logic     fwd_valid_out,
  output var  txn_req_t fwd_out
);

  resp_state_t s_r;   // registered state
  resp_state_t s_nxt; // next state

  ////////////////////////////////////////////////////////////////////////
  // next state: every routed request lands here, decode is untouched
  always_comb begin
    s_nxt           = '0;
    s_nxt.fwd       = req_in;
    s_nxt.cpl.tag   = req_in.tag;
    if (req_valid_in && !link_disable_in) begin
      // live link: pass through
      s_nxt.fwd_valid = 1'b1;
    end else if (req_valid_in) begin
      case (req_in.kind)
        TK_POSTED_WR: begin
          s_nxt.drop = 1'b1;
        end
        TK_IO_WR: begin
          s_nxt.cpl_valid  = 1'b1;
          s_nxt.cpl.status = CS_DONE;
        end
        default: begin
          s_nxt.cpl_valid  = 1'b1;
          s_nxt.cpl.status = CS_MASTER_ABORT;
          s_nxt.cpl.data   = `ABORT_DATA;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign cpl_valid_out = s_r.cpl_valid;
  assign cpl_out       = s_r.cpl;
  assign drop_out      = s_r.drop;
  assign fwd_valid_out = s_r.fwd_valid;
  assign fwd_out       = s_r.fwd;

endmodule : port_abort_responder
`default_nettype wire

// ---- port_link_ctl_sts.sv ----
// What this block does
// - ext sync bit extends fts, ts2
// - common clock bit read/write
// - common clock switches l0s latency 110->010
// - writing one to retrain starts retraining
// - retrain bit always reads zero
// - disable bit downs link, reset zero
// - disabled port still decodes, aborts locally
// - disabled: reads master abort, all ones
// - completion boundary bit reads zero
// - aspm control two bits, 00 disabled
// - slot clock status reads one
// - training bit set in config/recovery
// - training bit clears on reaching l0
// - training error on config/recovery to detect
// - negotiated width x1, x4, x8
// - link speed reads 1h
//
// Purpose: link control, link status and link capability registers of one root port
// Assumes: dword config access; physical and transaction layers on the same clock
// Notes:   read data returns one cycle after the read strobe
//          link_control and link_status share the dword at 0x74
//          the capability dword at 0x70 follows the common clock bit
//          status bits follow the link state sampled at each edge
//          a disabled link keeps its decode and answers locally
//          only the low control byte holds storage
//          all outputs come straight from flops
`timescale 1ns/1ps
`default_nettype none
`include "link_regs.svh"

module port_link_ctl_sts
  import link_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  // configuration access
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [31:0] cfg_wdata_in,
  output var  logic [31:0] cfg_rdata_out,
  output var  logic        cfg_rvalid_out,
  // physical layer status
  input  wire ltssm_t      ltssm_state_in,
  input  wire logic [5:0]  phy_width_in,
  // physical layer control
  output var  logic        retrain_req_out,
  output var  logic        link_disable_out,
  output var  logic        ext_sync_out,
  output var  logic        common_clk_out,
  output var  logic [1:0]  aspm_ctl_out,
  output var  logic [2:0]  l0s_exit_lat_out,
  // routed transactions
  input  wire logic        req_valid_in,
  input  wire txn_req_t    req_in,
  output var  logic        cpl_valid_out,
  output var  cpl_t        cpl_out,
  output var  logic        drop_out,
  output var  logic        fwd_valid_out,
  output var  txn_req_t    fwd_out
);

  ////////////////////////////////////////////////////////////////////////
  // state: every register field lives in one struct
  // one comb block fills the copy, one clocked block stores it

  regs_state_t s_r;   // registered state
  regs_state_t s_nxt; // next state

  ////////////////////////////////////////////////////////////////////////
  // helpers, shared by the images and the next state

  // true while training passes through config or recovery
  // polling is left out, only these two states raise the bit
  function automatic logic in_training(input ltssm_t st);
    in_training = (st == LT_CONFIG) || (st == LT_RECOVERY);
  endfunction : in_training

  // advertised l0s exit latency for the clocking mode
  // used by the capability image and the latency output alike
  function automatic logic [2:0] l0s_lat(input logic common);
    l0s_lat = common ? `CAP_L0S_EXIT_COMMON : `CAP_L0S_EXIT_ASYNC;
  endfunction : l0s_lat

  // only the x1, x4 and x8 widths are reported
  // reserved codes from the phy read back as no link
  function automatic logic [5:0] legal_width(input logic [5:0] w);
    case (w)
      `STS_WIDTH_X1, `STS_WIDTH_X4, `STS_WIDTH_X8: legal_width = w;
      default:                                      legal_width = `STS_WIDTH_NONE;
    endcase
  endfunction : legal_width

  // true when a byte address falls in the dword at off, lanes ignored
  function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
    dword_hit = (addr[7:2] == off[7:2]);
  endfunction : dword_hit

  ////////////////////////////////////////////////////////////////////////
  // register images

  logic [15:0] ctl_image; // link_control as read
  logic [15:0] sts_image; // link_status as read
  logic [31:0] cap_image; // link capabilities as read

  // control half: stored fields plus bits that read zero
  always_comb begin
    ctl_image = 16'h0000;
    ctl_image[`CTL_EXT_SYNC_BIT]   = s_r.ctl.ext_sync;
    ctl_image[`CTL_COMMON_CLK_BIT] = s_r.ctl.common_clk;
    ctl_image[`CTL_RETRAIN_BIT]    = 1'b0;
    ctl_image[`CTL_DISABLE_BIT]    = s_r.ctl.link_disable;
    ctl_image[`CTL_RCB_BIT]        = 1'b0;
    ctl_image[`CTL_ASPM_LSB +: 2]  = s_r.ctl.aspm;
  end

  // status half: fixed fields around the live link state
  always_comb begin
    // bit 12 slot clock, 11 training, 10 error, 9:4 width, 3:0 speed
    // reserved status bits zero
    sts_image = {3'h0,
                 `STS_SLOT_CLK,
                 s_r.training,
                 s_r.train_err,
                 s_r.width,
                 `STS_SPEED_2G5};
  end

  // capability dword, only the l0s latency field moves
  always_comb begin
    // port, l1 latency, aspm support, width and speed fixed
    cap_image = {`CAP_PORT_NUM, 6'h00, `CAP_L1_EXIT, l0s_lat(s_r.ctl.common_clk),
                 `CAP_ASPM_SUPPORT, `CAP_MAX_WIDTH, `CAP_MAX_SPEED};
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  // training, error and width all look at one sampled state,
  // so they never disagree about which edge a change belongs to

  logic ctl_hit; // access to the control/status dword
  logic cap_hit; // access to the capability dword

  // dword decode of the config address
  always_comb begin
    ctl_hit = dword_hit(cfg_addr_in, `LINK_CTL_OFF);
    cap_hit = dword_hit(cfg_addr_in, `LINK_CAP_OFF);
  end

  // next value of every field; strobes fall back each cycle
  always_comb begin
    // default: every stored field holds
    s_nxt         = s_r;
    s_nxt.retrain = 1'b0;
    s_nxt.rvalid  = 1'b0;
    // keep the state seen at this edge for the detect edge below
    s_nxt.prev_lt = ltssm_state_in;

    // control writes, low byte only holds fields
    // retrain, boundary and reserved bits have no storage behind them
    // a write with be[0] low leaves every control field untouched
    if (cfg_wr_in && ctl_hit && cfg_be_in[0]) begin
      s_nxt.ctl.ext_sync     = cfg_wdata_in[`CTL_EXT_SYNC_BIT];
      s_nxt.ctl.common_clk   = cfg_wdata_in[`CTL_COMMON_CLK_BIT];
      s_nxt.ctl.link_disable = cfg_wdata_in[`CTL_DISABLE_BIT];
      s_nxt.ctl.aspm         = cfg_wdata_in[`CTL_ASPM_LSB +: 2];
      s_nxt.retrain          = cfg_wdata_in[`CTL_RETRAIN_BIT];
    end
    // high control byte and status writes ignored

    if (in_training(ltssm_state_in)) begin
      s_nxt.training = 1'b1;
    end else if (ltssm_state_in == LT_L0) begin
      s_nxt.training = 1'b0;
    end else begin
      // other states hold it, e.g. detect after a failure
      s_nxt.training = s_r.training;
    end

    // failed training error
    // compares with the previous sample, so a one-edge hop is caught
    if (in_training(s_r.prev_lt) && ltssm_state_in == LT_DETECT) begin
      s_nxt.train_err = 1'b1;
    end else if (ltssm_state_in == LT_L0) begin
      // successful training clears it
      s_nxt.train_err = 1'b0;
    end else begin
      // no set and no clear: hold
      s_nxt.train_err = s_r.train_err;
    end

    // negotiated width
    // width lines mean nothing outside l0, so only l0 loads them
    if (ltssm_state_in == LT_L0) begin
      // reserved codes become no link
      s_nxt.width = legal_width(phy_width_in);
    end else if (ltssm_state_in == LT_DETECT) begin
      s_nxt.width = `STS_WIDTH_NONE;
    end else begin
      // training and low power states keep the last width
      s_nxt.width = s_r.width;
    end

    // read path, unmapped dwords read zero
    // the image is taken before a write on the same edge lands
    if (cfg_rd_in) begin
      s_nxt.rvalid = 1'b1;
      if (ctl_hit) begin
        // status above control in one dword
        s_nxt.rdata = {sts_image, ctl_image};
      end else if (cap_hit) begin
        // capability dword
        s_nxt.rdata = cap_image;
      end else begin
        // unmapped address
        s_nxt.rdata = 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // disable resets zero
      // constants only here; prev_lt at detect avoids a false error
      s_r          <= '0;
      s_r.ctl      <= '0;
      s_r.prev_lt  <= LT_DETECT;
      s_r.width    <= `STS_WIDTH_NONE;
    end else begin
      // register the next state
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  // config read answer
  assign cfg_rdata_out    = s_r.rdata;
  assign cfg_rvalid_out   = s_r.rvalid;
  assign retrain_req_out  = s_r.retrain;
  assign link_disable_out = s_r.ctl.link_disable;
  assign ext_sync_out     = s_r.ctl.ext_sync;
  assign common_clk_out   = s_r.ctl.common_clk;
  assign aspm_ctl_out     = s_r.ctl.aspm;
  logic [2:0] l0s_lat_r; // registered advertised latency
  // latency from the next state, moves with common_clk_out
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // asynchronous clocking after reset
      l0s_lat_r <= `CAP_L0S_EXIT_ASYNC;
    end else begin
      l0s_lat_r <= l0s_lat(s_nxt.ctl.common_clk);
    end
  end
  assign l0s_exit_lat_out = l0s_lat_r;

  ////////////////////////////////////////////////////////////////////////
  // decode unchanged, local abort
  // the responder sees the registered disable, one edge after the write
  port_abort_responder u_resp (
    .sys_clk_in      (sys_clk_in),
    .resetn_in       (resetn_in),
    .link_disable_in (s_r.ctl.link_disable),
    .req_valid_in    (req_valid_in),
    .req_in          (req_in),
    .cpl_valid_out   (cpl_valid_out),
    .cpl_out         (cpl_out),
    .drop_out        (drop_out),
    .fwd_valid_out   (fwd_valid_out),
    .fwd_out         (fwd_out)
  );

endmodule : port_link_ctl_sts
`default_nettype wire

// ---- testbench.sv ----
// Purpose: directed bench for the port link register block
// Assumes: partner model drives the link state
// Notes:   phy_en holds the partner in reset for reset checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import link_pkg::*;
  logic sys_clk_in, resetn_in, cfg_wr_in, cfg_rd_in, req_valid_in, phy_en, fail_r;
  logic [7:0]  cfg_addr_in;
  logic [3:0]  cfg_be_in;
  logic [31:0] cfg_wdata_in, cfg_rdata_out, d;
  logic [5:0]  phy_width_in, width_cfg;
  logic [2:0]  lat;
  logic        cfg_rvalid_out, retrain, dis, drop_out, cpl_valid_out, fwd_valid_out, ext_sync, cclk;
  logic [1:0]  aspm;
  ltssm_t      lt;
  txn_req_t    req_in, fwd_out;
  cpl_t        cpl_out;
  int          fail_count, num_checks;
  port_link_ctl_sts port_link_ctl_sts_inst (.sys_clk_in, .resetn_in, .cfg_addr_in, .cfg_be_in, .cfg_wr_in,
    .cfg_rd_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .ltssm_state_in(lt), .phy_width_in,
    .retrain_req_out(retrain), .link_disable_out(dis), .ext_sync_out(ext_sync), .common_clk_out(cclk),
    .aspm_ctl_out(aspm), .l0s_exit_lat_out(lat), .req_valid_in, .req_in, .cpl_valid_out, .cpl_out, .drop_out,
    .fwd_valid_out, .fwd_out);
  link_phy_model link_phy_model_inst (.sys_clk_in, .resetn_in(resetn_in && phy_en), .retrain_in(retrain),
    .disable_in(dis), .fail_in(fail_r), .width_cfg_in(width_cfg), .state_out(lt), .width_out(phy_width_in));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic wait_state(input ltssm_t s);
    for (int n = 0; n < 64 && lt !== s; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    if (lt !== s) begin
      fail_count++;
      $display("CHECK FAILED t=%0t link state wait ran out", $time);
      finish_test();
    end
  endtask : wait_state
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    @(posedge sys_clk_in);
    cfg_addr_in  <= a;
    cfg_be_in    <= be;
    cfg_wdata_in <= v;
    cfg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    cfg_wr_in <= 1'b0;
  endtask : cfg_write
  task automatic cfg_read(input logic [7:0] a);
    @(posedge sys_clk_in);
    cfg_addr_in <= a;
    cfg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    d = cfg_rdata_out;
  endtask : cfg_read
  task automatic send_req(input txn_kind_t k, input logic [7:0] t);
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_in       <= '{k, t};
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    #1;
  endtask : send_req
  ////////////////////////////////////////
  task automatic test_reset();
    cfg_read(8'h74);
    check(d, 32'h10010000);
    cfg_read(8'h70);
    check(d, 32'h0203e481);
    cfg_read(8'h40);
    check(d, 32'h0);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_ctl();
    cfg_write(8'h74, 4'h1, 32'hffffffff);
    #1;
    check({31'h0, retrain}, 32'h1);
    check({27'h0, ext_sync, cclk, dis, aspm}, 32'h1f);
    cfg_read(8'h74);
    check(d & 32'hffff, 32'h00d3);
    check({29'h0, lat}, 32'h2);
    cfg_read(8'h70);
    check(d, 32'h0203a481);
    cfg_write(8'h74, 4'he, 32'h0);
    cfg_read(8'h76);
    check(d & 32'hffff, 32'h00d3);
    for (int i = 0; i < 4; i++) begin
      cfg_write(8'h74, 4'h1, 32'(i));
      cfg_read(8'h74);
      check(d & 32'hffff, 32'(i));
    end
    check({29'h0, lat}, 32'h6);
    check({27'h0, ext_sync, cclk, dis, aspm}, 32'h3);
    $display("test_ctl done");
  endtask : test_ctl
  task automatic test_train();
    phy_en <= 1'b1;
    wait_state(LT_L0);
    cfg_read(8'h74);
    check(d >> 16, 32'h1081);
    for (int i = 0; i < 2; i++) begin
      width_cfg <= i ? 6'h04 : 6'h01;
      repeat (2) @(posedge sys_clk_in);
      cfg_read(8'h74);
      check({26'h0, d[25:20]}, i ? 32'h4 : 32'h1);
    end
    cfg_write(8'h74, 4'h1, 32'h40);
    cfg_write(8'h74, 4'h1, 32'h60);
    wait_state(LT_RECOVERY);
    cfg_read(8'h74);
    check({31'h0, d[27]}, 32'h1);
    fail_r <= 1'b1;
    wait_state(LT_DETECT);
    cfg_read(8'h74);
    check({25'h0, d[26:20]}, 32'h40);
    fail_r <= 1'b0;
    wait_state(LT_L0);
    cfg_read(8'h74);
    check({25'h0, d[27], d[26]}, 32'h0);
    $display("test_train done");
  endtask : test_train
  task automatic test_disabled();
    cfg_write(8'h74, 4'h1, 32'h10);
    for (int k = 0; k < 4; k++) begin
      send_req(txn_kind_t'(k), 8'h10 + 8'(k));
      check({drop_out, cpl_valid_out, fwd_valid_out}, k ? 32'h2 : 32'h4);
      if (k != 0) begin
        check({cpl_out.status, cpl_out.tag}, {k == 1 ? 2'h0 : 2'h1, 8'h10 + 8'(k)});
        check(cpl_out.data, k == 1 ? 32'h0 : 32'hffffffff);
      end
    end
    cfg_write(8'h74, 4'h1, 32'h0);
    send_req(TK_READ, 8'h5a);
    check({fwd_valid_out, fwd_out}, {1'b1, TK_READ, 8'h5a});
    $display("test_disabled done");
  endtask : test_disabled
  ////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    {resetn_in, cfg_wr_in, cfg_rd_in, req_valid_in, phy_en, fail_r} = 6'h0;
    {cfg_addr_in, cfg_be_in, cfg_wdata_in, req_in} = '0;
    width_cfg = 6'h08;
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    test_reset();
    test_ctl();
    test_train();
    test_disabled();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
